// File: inc/acs_map.svh
// Bit positions, command codes and cycle counts of the sequencer pair.
// Assumes the converter clock is the only clock of both ends.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// Configuration word fields
`define ACS_B_CH 0
`define ACS_B_ACQ 4
`define ACS_B_SYNC 6
`define ACS_B_HB 7
`define ACS_B_BW 8
`define ACS_B_CMD 9
`define ACS_CFG_RST 13'h0000

// Command field codes
`define ACS_CMD_STANDBY 3'h0
`define ACS_CMD_FULCAL 3'h1
`define ACS_CMD_AZERO 3'h2
`define ACS_CMD_RESET 3'h3
`define ACS_CMD_START 3'h4

// Converter clock counts: acquisition 9, 15, 47, 79
`define ACS_ACQ_0 9'h009
`define ACS_ACQ_1 9'h00F
`define ACS_ACQ_2 9'h02F
`define ACS_ACQ_3 9'h04F
`define ACS_CONV_CYC 9'h02C
`define ACS_CAL_CYC 9'h190
`define ACS_AZ_CYC 9'h050

// Host strobe low time and gap between strobes
`define ACS_STROBE_CYC 4'h7
`define ACS_GAP_CYC 4'h8

// Host command port offsets
`define ACS_H_CFG 4'h0
`define ACS_H_RD 4'h4
`define ACS_H_STAT 4'h8
`define ACS_H_RES 4'hC

`endif

// File: inc/acs_pkg.sv
// Types shared by the converter end and the host end.
// Assumes acs_map.svh supplies the numeric constants.
`default_nettype none
package acs_pkg;
    typedef logic [12:0] acs_word_t;
    typedef enum logic [5:0] {
        ACS_SLEEP = 6'h01,
        ACS_IDLE = 6'h02,
        ACS_CAL = 6'h04,
        ACS_ACQ = 6'h08,
        ACS_WSYNC = 6'h10,
        ACS_CONV = 6'h20
    } acs_dstate_e;
    typedef enum logic [3:0] {
        ACS_H_IDLE = 4'h1,
        ACS_H_WAIT = 4'h2,
        ACS_H_LOW = 4'h4,
        ACS_H_GAP = 4'h8
    } acs_hstate_e;
endpackage : acs_pkg
`default_nettype wire

// File: inc/acs_if.sv
// Parallel bus between host and converter, with pin resolution.
// Assumes each end drives a pin only while its enable is high.
`default_nettype none
interface acs_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [12:0] hdb;
    logic hdb_oe;
    logic [12:0] ddb;
    logic ddb_oe;
    logic [12:0] db;
    logic rdy_n;
    logic sleep_indicator_n;
    logic hsync;
    logic hsync_oe;
    logic dsync;
    logic dsync_oe;
    logic sync;

    // Wire levels of the shared data bus and sync pin
    assign db = ddb_oe ? ddb : (hdb_oe ? hdb : 13'h0000);
    assign sync = dsync_oe ? dsync : (hsync_oe ? hsync : 1'b0);

    modport dev (input cs_n, input rd_n, input wr_n, input db,
        input sync, output ddb, output ddb_oe, output rdy_n,
        output sleep_indicator_n, output dsync, output dsync_oe);
    modport host (output cs_n, output rd_n, output wr_n, output hdb,
        output hdb_oe, output hsync, output hsync_oe, input db,
        input rdy_n, input sleep_indicator_n, input sync);
endinterface : acs_if
`default_nettype wire

// File: hw/acs_code_calc.sv
// Two's complement result coding of the held input difference.
// Assumes difference and span are in the same unit, span unsigned.
`default_nettype none
`include "acs_map.svh"
module acs_code_calc (
    input wire logic signed [15:0] diff,
    input wire logic [15:0] span,
    output logic signed [12:0] code
);
    logic signed [31:0] num;
    logic signed [31:0] half;
    logic signed [31:0] quot;

    // Scale by 4096, round to nearest, limit to -4096..4095
    always_comb begin
        num = {{4{diff[15]}}, diff, 12'h000};
        half = $signed({17'h0_0000, span[15:1]});
        if (span == 16'h0000) begin
            quot = diff[15] ? -32'sd4096 : 32'sd4095;
        end else if (diff[15]) begin
            quot = (num - half) / $signed({16'h0000, span});
        end else begin
            quot = (num + half) / $signed({16'h0000, span});
        end
        if (quot > 32'sd4095) begin
            code = 13'h0FFF;
        end else if (quot < -32'sd4096) begin
            code = 13'h1000;
        end else begin
            code = quot[12:0];
        end
    end
endmodule : acs_code_calc
`default_nettype wire

// File: hw/acs_dev.sv
// Converter end: configuration, command and conversion sequencer.
// Assumes the host pins arrive asynchronously; all are synchronised.
//
// Contract
// - 8-bit free run: second read starts acquisition
// - Sync output rises when acquisition count ends
// - Conversion end drops ready and sync output
// - 8-bit reads give low byte, then high
// - Second result read restarts the sequence
// - 13-bit free run: single read starts acquisition
// - 13-bit read returns whole result, raises ready
// - Host writes channel byte, then sync/start byte
// - Sync edge or second read raises ready
// - Only sync rising edge starts sync-in conversion
// - Channel tracked from write until sync edge
// - Sync-in 8-bit: reads raise ready, sync converts
// - 13-bit sync-in: single write, read raises ready
// - 8-bit standby: byte with select, then command
// - 13-bit standby: single write, command zero
// - Reset command aborts work, ready goes low
// - Result is clamped rounded two's complement
// - Low byte with select opens upper byte
// - Standby entry and exit levels of pins
// - Acquisition of 9, 15, 47 or 79 cycles
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
`include "acs_map.svh"
module acs_dev (
    input wire logic clock,
    input wire logic rst,
    acs_if.dev bus,
    input wire logic signed [15:0] analog_diff,
    input wire logic [15:0] ref_span,
    output logic [3:0] mux_channel,
    output logic track_en
);
    acs_pkg::acs_dstate_e state_q;
    acs_pkg::acs_word_t cfg_q;
    logic [16:0] pin_v;
    logic [16:0] s1_q;
    logic [16:0] s2_q;
    logic [16:0] s3_q;
    logic hb_pend_q;
    logic cmd_go_q;
    logic rd_hi_q;
    logic [8:0] cnt_q;
    logic [12:0] hold_q;
    logic [12:0] result_q;
    logic [12:0] ddb_q;
    logic signed [12:0] code;
    logic wide;
    logic sync_mode;
    logic start_cfg;
    logic rd_rise;
    logic wr_rise;
    logic sync_rise;
    logic rd_trig;
    logic conv_start;
    logic conv_done;
    logic [8:0] acq_len;

    // Pin vector: sync, chip select, read, write, data
    assign pin_v = {bus.sync, bus.cs_n, bus.rd_n, bus.wr_n, bus.db};

    // Two-stage synchroniser plus one delay stage for edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 17'h1_E000;
            s2_q <= 17'h1_E000;
            s3_q <= 17'h1_E000;
        end else begin
            s1_q <= pin_v;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Decoded configuration and strobe edges
    assign wide = cfg_q[`ACS_B_BW];
    assign sync_mode = cfg_q[`ACS_B_SYNC];
    assign start_cfg = cfg_q[`ACS_B_CMD +: 3] == `ACS_CMD_START;
    assign rd_rise = s2_q[14] & ~s3_q[14] & ~s3_q[15];
    assign wr_rise = s2_q[13] & ~s3_q[13] & ~s3_q[15];
    assign sync_rise = sync_mode & s2_q[16] & ~s3_q[16];
    assign rd_trig = rd_rise & (wide | rd_hi_q);

    // Acquisition length from configuration bits five and four
    always_comb begin
        unique case (cfg_q[`ACS_B_ACQ +: 2])
            2'h0: acq_len = `ACS_ACQ_0;
            2'h1: acq_len = `ACS_ACQ_1;
            2'h2: acq_len = `ACS_ACQ_2;
            2'h3: acq_len = `ACS_ACQ_3;
        endcase
    end

    // Configuration writes: one word, or low then high byte
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_q <= `ACS_CFG_RST;
            hb_pend_q <= 1'b0;
            cmd_go_q <= 1'b0;
        end else begin
            cmd_go_q <= 1'b0;
            if (wr_rise) begin
                if (wide) begin
                    cfg_q <= s2_q[12:0];
                    cmd_go_q <= 1'b1;
                end else if (hb_pend_q) begin
                    cfg_q[12:8] <= s2_q[4:0];
                    hb_pend_q <= 1'b0;
                    cmd_go_q <= 1'b1;
                end else begin
                    cfg_q[7:0] <= s2_q[7:0];
                    hb_pend_q <= s2_q[`ACS_B_HB];
                end
            end
        end
    end

    // Conversion boundaries
    always_comb begin
        conv_start = 1'b0;
        unique case (state_q)
            acs_pkg::ACS_IDLE: conv_start = start_cfg & sync_rise;
            acs_pkg::ACS_ACQ: conv_start = cnt_q == 9'h001;
            acs_pkg::ACS_WSYNC: conv_start = sync_rise;
            acs_pkg::ACS_SLEEP, acs_pkg::ACS_CAL,
            acs_pkg::ACS_CONV: conv_start = 1'b0;
        endcase
    end
    assign conv_done = state_q == acs_pkg::ACS_CONV && cnt_q == 9'h001;

    // Sequencer: commands take priority over the running activity
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= acs_pkg::ACS_SLEEP;
            cnt_q <= 9'h000;
        end else if (cmd_go_q) begin
            unique case (cfg_q[`ACS_B_CMD +: 3])
                `ACS_CMD_STANDBY: state_q <= acs_pkg::ACS_SLEEP;
                `ACS_CMD_FULCAL: begin
                    state_q <= acs_pkg::ACS_CAL;
                    cnt_q <= `ACS_CAL_CYC;
                end
                `ACS_CMD_AZERO: begin
                    state_q <= acs_pkg::ACS_CAL;
                    cnt_q <= `ACS_AZ_CYC;
                end
                `ACS_CMD_RESET: state_q <= acs_pkg::ACS_IDLE;
                `ACS_CMD_START: begin
                    if (state_q == acs_pkg::ACS_SLEEP) begin
                        state_q <= acs_pkg::ACS_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else begin
            unique case (state_q)
                acs_pkg::ACS_SLEEP: begin
                end
                acs_pkg::ACS_IDLE: begin
                    if (conv_start) begin
                        state_q <= acs_pkg::ACS_CONV;
                        cnt_q <= `ACS_CONV_CYC;
                    end else if (start_cfg && rd_trig && sync_mode) begin
                        state_q <= acs_pkg::ACS_WSYNC;
                    end else if (start_cfg && rd_trig) begin
                        state_q <= acs_pkg::ACS_ACQ;
                        cnt_q <= acq_len;
                    end
                end
                acs_pkg::ACS_ACQ: begin
                    cnt_q <= cnt_q - 9'h001;
                    if (conv_start) begin
                        state_q <= acs_pkg::ACS_CONV;
                        cnt_q <= `ACS_CONV_CYC;
                    end
                end
                acs_pkg::ACS_WSYNC: begin
                    if (conv_start) begin
                        state_q <= acs_pkg::ACS_CONV;
                        cnt_q <= `ACS_CONV_CYC;
                    end
                end
                acs_pkg::ACS_CONV, acs_pkg::ACS_CAL: begin
                    cnt_q <= cnt_q - 9'h001;
                    if (cnt_q == 9'h001) begin
                        state_q <= acs_pkg::ACS_IDLE;
                    end
                end
            endcase
        end
    end

    // Read byte pointer; cleared by writes and fresh results
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_hi_q <= 1'b0;
        end else if (wr_rise || conv_done) begin
            rd_hi_q <= 1'b0;
        end else if (rd_rise && !wide) begin
            rd_hi_q <= ~rd_hi_q;
        end
    end

    // Sample held at conversion start, published at its end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_q <= 13'h0000;
            result_q <= 13'h0000;
        end else begin
            if (conv_start) begin
                hold_q <= code;
            end
            if (conv_done) begin
                result_q <= hold_q;
            end
        end
    end

    acs_code_calc u_calc (
        .diff(analog_diff),
        .span(ref_span),
        .code(code)
    );

    // Read data: whole word, or low byte then high byte
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ddb_q <= 13'h0000;
        end else if (wide) begin
            ddb_q <= result_q;
        end else if (rd_hi_q) begin
            ddb_q <= {8'h00, result_q[12:8]};
        end else begin
            ddb_q <= {5'h00, result_q[7:0]};
        end
    end

    // Pin outputs
    assign bus.ddb = ddb_q;
    assign bus.ddb_oe = ~s2_q[14] & ~s2_q[15];
    assign bus.rdy_n = state_q != acs_pkg::ACS_IDLE;
    assign bus.sleep_indicator_n = state_q != acs_pkg::ACS_SLEEP;
    assign bus.dsync = state_q == acs_pkg::ACS_CONV;
    assign bus.dsync_oe = ~sync_mode;

    // Channel tracking until the sample is held
    assign mux_channel = cfg_q[`ACS_B_CH +: 4];
    assign track_en = state_q == acs_pkg::ACS_IDLE ||
        state_q == acs_pkg::ACS_ACQ || state_q == acs_pkg::ACS_WSYNC;
endmodule : acs_dev
`default_nettype wire

// File: hw/acs_host.sv
// Host end: turns register orders into strobe sequences on the bus.
// Assumes a software port on the same clock; bus inputs are pins.
`default_nettype none
`include "acs_map.svh"
module acs_host (
    input wire logic clock,
    input wire logic rst,
    acs_if.host bus,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire logic sync_pulse
);
    acs_pkg::acs_hstate_e st_q;
    acs_pkg::acs_word_t word_q;
    acs_pkg::acs_word_t res_q;
    logic [14:0] s1_q;
    logic [14:0] s2_q;
    logic wide_q;
    logic is_rd_q;
    logic step_q;
    logic [3:0] cnt_q;
    logic [15:0] rdata_q;
    logic hsync_q;
    logic [12:0] out_w;
    logic go_ok;
    logic last;

    // Synchronise ready, standby flag and data bus; reset to standby levels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 15'h2000;
            s2_q <= 15'h2000;
        end else begin
            s1_q <= {bus.sleep_indicator_n, bus.rdy_n, bus.db};
            s2_q <= s1_q;
        end
    end

    // Ready low, or standby for writes only, allows a strobe
    assign go_ok = ~s2_q[13] | (~is_rd_q & ~s2_q[14]);
    assign last = wide_q | step_q;

    // Word driven: full word, low byte with select, or upper byte
    always_comb begin
        if (wide_q) begin
            out_w = word_q;
        end else if (!step_q) begin
            out_w = {5'h00, 1'b1, word_q[6:0]};
        end else begin
            out_w = {8'h00, word_q[12:8]};
        end
    end

    // Strobe sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= acs_pkg::ACS_H_IDLE;
            word_q <= `ACS_CFG_RST;
            res_q <= 13'h0000;
            wide_q <= 1'b0;
            is_rd_q <= 1'b0;
            step_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            unique case (st_q)
                acs_pkg::ACS_H_IDLE: begin
                    step_q <= 1'b0;
                    if (wr_stb && addr == `ACS_H_CFG) begin
                        word_q <= wdata[12:0];
                        is_rd_q <= 1'b0;
                        st_q <= acs_pkg::ACS_H_WAIT;
                    end else if (wr_stb && addr == `ACS_H_RD) begin
                        is_rd_q <= 1'b1;
                        st_q <= acs_pkg::ACS_H_WAIT;
                    end
                end
                acs_pkg::ACS_H_WAIT: begin
                    if (go_ok) begin
                        st_q <= acs_pkg::ACS_H_LOW;
                        cnt_q <= `ACS_STROBE_CYC;
                    end
                end
                acs_pkg::ACS_H_LOW: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        st_q <= acs_pkg::ACS_H_GAP;
                        cnt_q <= `ACS_GAP_CYC;
                        if (is_rd_q && wide_q) begin
                            res_q <= s2_q[12:0];
                        end else if (is_rd_q && !step_q) begin
                            res_q[7:0] <= s2_q[7:0];
                        end else if (is_rd_q) begin
                            res_q[12:8] <= s2_q[4:0];
                        end
                    end
                end
                acs_pkg::ACS_H_GAP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        step_q <= 1'b1;
                        st_q <= last ? acs_pkg::ACS_H_IDLE
                                     : acs_pkg::ACS_H_WAIT;
                        if (last && !is_rd_q) begin
                            wide_q <= word_q[`ACS_B_BW];
                        end
                    end
                end
            endcase
        end
    end

    // Bus pins and sync pulse drive in sync-in mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hsync_q <= 1'b0;
        end else begin
            hsync_q <= sync_pulse;
        end
    end
    assign bus.cs_n = st_q != acs_pkg::ACS_H_LOW;
    assign bus.rd_n = ~(st_q == acs_pkg::ACS_H_LOW && is_rd_q);
    assign bus.wr_n = ~(st_q == acs_pkg::ACS_H_LOW && !is_rd_q);
    assign bus.hdb = out_w;
    assign bus.hdb_oe = !is_rd_q && st_q != acs_pkg::ACS_H_IDLE;
    assign bus.hsync = hsync_q;
    assign bus.hsync_oe = word_q[`ACS_B_SYNC];

    // Register reads, answered one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (rd_stb) begin
            unique case (addr)
                `ACS_H_CFG: rdata_q <= {3'h0, word_q};
                `ACS_H_STAT: rdata_q <= {12'h000,
                    st_q != acs_pkg::ACS_H_IDLE, s2_q[14], s2_q[13], wide_q};
                `ACS_H_RES: rdata_q <= {{3{res_q[12]}}, res_q};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign rdata = rdata_q;
endmodule : acs_host
`default_nettype wire

// File: testbench/acs_chk.sv
// Checker on the bus between the host end and the converter end.
// Assumes the bench wires it to the shared interface; one clock domain.
`default_nettype none
module acs_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic rdy_n,
    input wire logic sleep_indicator_n,
    input wire logic sync,
    input wire logic dsync,
    input wire logic dsync_oe,
    input wire logic ddb_oe,
    input wire logic hdb_oe
);
    logic [2:0] prev_q;
    logic [7:0] since_q;
    logic cause;

    // Cycles since a strobe was released or the sync pin rose
    assign cause = |({rd_n, wr_n, sync} & ~prev_q);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_q <= 3'h7;
            since_q <= 8'hFF;
        end else begin
            prev_q <= {rd_n, wr_n, sync};
            if (cause)
                since_q <= 8'h00;
            else if (since_q != 8'hFF)
                since_q <= since_q + 8'h01;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    rst_sleep_a: assert property (
        $fell(rst) |-> rdy_n && !sleep_indicator_n)
        else $error("ready or sleep level wrong after reset");
    sleep_busy_a: assert property (
        !sleep_indicator_n |-> rdy_n)
        else $error("ready low while asleep");
    wake_ready_a: assert property (
        $rose(sleep_indicator_n) |-> !rdy_n)
        else $error("ready not low on leaving sleep");
    conv_end_a: assert property (
        $fell(dsync) && dsync_oe && $past(dsync_oe) |-> !rdy_n)
        else $error("sync fell without ready low");
    acq_min_a: assert property (
        $rose(dsync) && dsync_oe |-> rdy_n && $past(rdy_n, 8))
        else $error("sync rose before acquisition ended");
    conv_len_a: assert property (
        $rose(dsync) && dsync_oe |-> dsync [*8])
        else $error("conversion phase cut short");
    ready_cause_a: assert property (
        $rose(rdy_n) |-> since_q <= 8'h08)
        else $error("ready rose with no strobe or sync");
    no_clash_a: assert property (
        !(ddb_oe && hdb_oe))
        else $error("both ends drive the data bus");
    strobe_len_a: assert property (
        $fell(rd_n) |-> (!rd_n && !cs_n) [*7])
        else $error("read strobe too short");
endmodule : acs_chk
`default_nettype wire

// File: testbench/tb_adc_host_command_sequencer.sv
// Bench: host end drives the converter end; a model predicts results.
// Assumes acs_pkg, acs_if, both ends and acs_chk are compiled first.
`default_nettype none
`include "acs_map.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, \
    got); end end
module tb_adc_host_command_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock;
    logic rst;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [15:0] rdata;
    logic sync_pulse;
    logic signed [15:0] analog_diff;
    logic [15:0] ref_span;
    logic [3:0] mux_channel;
    logic track_en;
    logic [15:0] lfsr_q;
    logic [15:0] exp_q;
    logic [3:0] ch;
    logic rdy_prev;
    logic sync_prev;
    int error_cnt = 0;
    int cmp_count = 0;
    int acq_len = 0;
    int acq_seen = 0;
    int acq_tab[4] = '{9, 15, 47, 79};

    acs_if link ();
    acs_dev u_acs_dev (.clock(clock), .rst(rst), .bus(link),
        .analog_diff(analog_diff), .ref_span(ref_span),
        .mux_channel(mux_channel), .track_en(track_en));
    acs_host u_acs_host (.clock(clock), .rst(rst), .bus(link),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .sync_pulse(sync_pulse));
    acs_chk u_acs_chk (.clock(clock), .rst(rst), .cs_n(link.cs_n),
        .rd_n(link.rd_n), .wr_n(link.wr_n), .rdy_n(link.rdy_n),
        .sleep_indicator_n(link.sleep_indicator_n), .sync(link.sync),
        .dsync(link.dsync), .dsync_oe(link.dsync_oe),
        .ddb_oe(link.ddb_oe), .hdb_oe(link.hdb_oe));

    // Clock of 50 ns
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Acquisition length, ready rise to sync rise
    always @(posedge clock) begin
        if (rdy_prev === 1'b0 && link.rdy_n === 1'b1)
            acq_len = 1;
        else if (link.rdy_n === 1'b1 && link.sync === 1'b0)
            acq_len = acq_len + 1;
        if (sync_prev === 1'b0 && link.sync === 1'b1)
            acq_seen = acq_len;
        rdy_prev = link.rdy_n;
        sync_prev = link.sync;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // Rounded, clamped two's complement code
    function automatic logic [15:0] model_code(input int d, input int s);
        int q;
        q = (2 * ((d < 0) ? -d : d) * 4096 + s) / (2 * s);
        if (d < 0)
            q = -q;
        if (q > 4095)
            q = 4095;
        if (q < -4096)
            q = -4096;
        return q[15:0];
    endfunction : model_code

    function automatic logic [15:0] cfg_word(input logic [2:0] cmd,
        input logic bw, input logic sy, input logic [1:0] acq);
        return {4'h0, cmd, bw, 1'b0, sy, acq, ch};
    endfunction : cfg_word

    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd

    // Polls one status bit under a bounded count
    task automatic wait_st(input int b, input logic v, input int n);
        logic [15:0] s;
        int k;
        k = 0;
        bus_rd(`ACS_H_STAT, s);
        while (s[b] !== v && k < n) begin
            bus_rd(`ACS_H_STAT, s);
            k++;
        end
        if (s[b] !== v) begin
            error_cnt++;
            $display("CHECK FAILED status bit %0d exp %0b got %0b", b, v,
                s[b]);
            tally_and_finish();
        end
    endtask : wait_st

    task automatic cfg(input logic [15:0] w);
        bus_wr(`ACS_H_CFG, w);
        wait_st(3, 1'b0, 200);
    endtask : cfg

    task automatic trig();
        bus_wr(`ACS_H_RD, 16'h0000);
        wait_st(3, 1'b0, 200);
    endtask : trig

    task automatic new_sample();
        logic [15:0] d;
        logic [15:0] s;
        @(posedge clock);
        lfsr_q = lfsr_next(lfsr_q);
        d = lfsr_q;
        lfsr_q = lfsr_next(lfsr_q);
        s = lfsr_q | 16'h0100;
        ch = {1'b0, lfsr_q[2:0]};
        analog_diff <= d;
        ref_span <= s;
        exp_q = model_code($signed(d), int'(s));
    endtask : new_sample

    task automatic sync_hit();
        @(posedge clock);
        sync_pulse <= 1'b1;
        repeat (10) @(posedge clock);
        sync_pulse <= 1'b0;
        wait_st(1, 1'b0, 100);
    endtask : sync_hit

    initial begin
        logic [15:0] v;
        int i;
        rst = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        sync_pulse = 1'b0;
        analog_diff = 16'h0000;
        ref_span = 16'h1000;
        lfsr_q = 16'h001B;
        ch = 4'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        bus_rd(`ACS_H_STAT, v);
        `CHK("sleep", 1'b0, v[2])
        `CHK("ready", 1'b1, v[1])
        bus_rd(4'h2, v);
        `CHK("unmapped", 16'h0000, v)
        // Free running: 13-bit at every acquisition, then 8-bit
        for (i = 0; i < 5; i++) begin
            new_sample();
            cfg(cfg_word(`ACS_CMD_START, i < 4, 1'b0, i[1:0]));
            `CHK("channel", ch, mux_channel)
            trig();
            wait_st(1, 1'b1, 20);
            wait_st(1, 1'b0, 100);
            `CHK("acq", acq_tab[i % 4], acq_seen)
            trig();
            bus_rd(`ACS_H_RES, v);
            `CHK("result", exp_q, v)
        end
        // Sync-in 13-bit: read raises ready, only sync converts
        new_sample();
        cfg(cfg_word(`ACS_CMD_START, 1'b1, 1'b1, 2'h0));
        trig();
        wait_st(1, 1'b1, 20);
        repeat (100) @(posedge clock);
        bus_rd(`ACS_H_STAT, v);
        `CHK("held", 1'b1, v[1])
        `CHK("tracking", 1'b1, track_en)
        sync_hit();
        trig();
        bus_rd(`ACS_H_RES, v);
        `CHK("sync result", exp_q, v)
        sync_hit();
        // Full calibration and auto-zero end with ready low
        for (i = 1; i < 3; i++) begin
            cfg(cfg_word(i[2:0], 1'b1, 1'b0, 2'h0));
            wait_st(1, 1'b0, 400);
        end
        // Standby in one write, left by the reset command
        cfg(cfg_word(`ACS_CMD_STANDBY, 1'b1, 1'b0, 2'h0));
        wait_st(2, 1'b0, 20);
        bus_rd(`ACS_H_STAT, v);
        `CHK("standby ready", 1'b1, v[1])
        cfg(cfg_word(`ACS_CMD_RESET, 1'b1, 1'b0, 2'h0));
        wait_st(1, 1'b0, 20);
        bus_rd(`ACS_H_STAT, v);
        `CHK("awake", 1'b1, v[2])
        // Sync-in 8-bit: second read raises ready, sync converts
        new_sample();
        cfg(cfg_word(`ACS_CMD_START, 1'b0, 1'b1, 2'h0));
        trig();
        sync_hit();
        trig();
        bus_rd(`ACS_H_RES, v);
        `CHK("sync byte result", exp_q, v)
        sync_hit();
        // 8-bit standby: select byte first, then command byte
        cfg(cfg_word(`ACS_CMD_STANDBY, 1'b0, 1'b0, 2'h0));
        wait_st(2, 1'b0, 20);
        bus_rd(`ACS_H_STAT, v);
        `CHK("byte standby", 4'h2, v[3:0])
        tally_and_finish();
    end
endmodule : tb_adc_host_command_sequencer
`default_nettype wire
